/* shared/write_sequencer_regs.vh */
/*
  Constants of the control write sequencer: register offsets, register fields,
  step word layout and timing figures.
  Assumes it is included by its bare name from the design files.
*/
`ifndef WRITE_SEQUENCER_REGS_VH
`define WRITE_SEQUENCER_REGS_VH

// Register offsets on the control port.
`define OFS_SOFT_RESET      8'h00
`define OFS_WRITE_INDEX     8'h6C
`define OFS_STEP_TARGET     8'h6D
`define OFS_STEP_PAYLOAD    8'h6E
`define OFS_LAUNCH          8'h6F
`define OFS_STATUS          8'h70

// Register fields.
`define LAUNCH_ENABLE_BIT   8
`define STATUS_INDEX_LSB    4
`define STATUS_BUSY_BIT     0
`define TARGET_WIDTH_LSB    12
`define TARGET_START_LSB    8
`define PAYLOAD_EOS_BIT     14
`define PAYLOAD_DELAY_LSB   8

// Register reset values.
`define RESET_WRITE_INDEX   5'h00
`define RESET_TARGET        15'h0000
`define RESET_PAYLOAD       15'h0000
`define RESET_LAUNCH        16'h0000

// Step word layout.
`define STEP_BITS           28
`define STEP_DATA_LSB       0
`define STEP_ADDR_LSB       8
`define STEP_START_LSB      16
`define STEP_WIDTH_LSB      20
`define STEP_DELAY_LSB      23
`define STEP_EOS_BIT        27

// Memory map of the sequence store.
`define RAM_DEPTH           32
`define STARTUP_INDEX       6'h00
`define SHUTDOWN_INDEX      6'h20
`define LAST_INDEX          6'h30

// Timing.
`define STEP_UNIT_NS        62500
`define CLK_PERIOD_NS       10
`define DELAY_OFFSET_TICKS  16'h0008

`endif

/* core/sequence_step_rom.v */
/*
  Default step table of the write sequencer: start-up steps 0 to 31 and the
  fixed shutdown steps 32 to 48, looked up combinationally by index.
  Assumes the caller registers whatever it drives out of the block.
*/
`timescale 1ns/100ps
`include "write_sequencer_regs.vh"

module sequence_step_rom (
  // Lookup.
  input  wire [5:0]                index,
  output reg  [`STEP_BITS-1:0]     step_word
);

  // Packs one step; width is given as the field width code.
  function [`STEP_BITS-1:0] step;
    input       eos;
    input [3:0] dly;
    input [2:0] wcode;
    input [3:0] start;
    input [7:0] addr;
    input [7:0] data;
    begin
      step = {eos, dly, wcode, start, addr, data};
    end
  endfunction

  // Steps 0 to 63 beyond the listed ones are dummy writes to address FFh.
  always @* begin
    case (index)
      6'h00: step_word = step(1'b0, 4'h0, 3'h4, 4'h0, 8'h04, 8'h1A);
      6'h01: step_word = step(1'b0, 4'h9, 3'h0, 4'h1, 8'h41, 8'h01);
      6'h02: step_word = step(1'b0, 4'h0, 3'h1, 4'h0, 8'h11, 8'h03);
      6'h03: step_word = step(1'b0, 4'h0, 3'h0, 4'h1, 8'h41, 8'h00);
      6'h04: step_word = step(1'b0, 4'hB, 3'h7, 4'h0, 8'h05, 8'hF7);
      6'h05: step_word = step(1'b0, 4'h0, 3'h1, 4'h0, 8'h11, 8'h00);
      6'h06: step_word = step(1'b0, 4'h0, 3'h1, 4'h3, 8'h05, 8'h00);
      6'h07: step_word = step(1'b0, 4'h0, 3'h1, 4'h1, 8'h05, 8'h01);
      6'h08: step_word = step(1'b0, 4'h0, 3'h0, 4'h0, 8'h04, 8'h01);
      6'h09: step_word = step(1'b0, 4'h0, 3'h1, 4'h0, 8'h0E, 8'h03);
      6'h0A: step_word = step(1'b0, 4'h0, 3'h1, 4'h0, 8'h0D, 8'h03);
      6'h0B: step_word = step(1'b0, 4'h0, 3'h1, 4'h0, 8'h0F, 8'h03);
      6'h0C: step_word = step(1'b0, 4'h0, 3'h0, 4'h1, 8'h16, 8'h01);
      6'h0D: step_word = step(1'b0, 4'h5, 3'h1, 4'h2, 8'h12, 8'h03);
      6'h0F: step_word = step(1'b0, 4'h0, 3'h0, 4'h4, 8'h04, 8'h00);
      6'h10: step_word = step(1'b0, 4'h6, 3'h0, 4'h0, 8'h62, 8'h01);
      6'h12: step_word = step(1'b0, 4'h0, 3'h7, 4'h0, 8'h5A, 8'h11);
      6'h13: step_word = step(1'b0, 4'h0, 3'h7, 4'h0, 8'h5E, 8'h11);
      6'h14: step_word = step(1'b0, 4'h0, 3'h7, 4'h0, 8'h5A, 8'h33);
      6'h15: step_word = step(1'b0, 4'h0, 3'h7, 4'h0, 8'h5E, 8'h33);
      6'h16: step_word = step(1'b0, 4'h0, 3'h1, 4'h0, 8'h45, 8'h02);
      6'h17: step_word = step(1'b0, 4'hC, 3'h3, 4'h0, 8'h43, 8'h0F);
      6'h18: step_word = step(1'b0, 4'h7, 3'h3, 4'h0, 8'h43, 8'h0F);
      6'h1A: step_word = step(1'b0, 4'h0, 3'h7, 4'h0, 8'h5A, 8'h77);
      6'h1B: step_word = step(1'b0, 4'h0, 3'h7, 4'h0, 8'h5E, 8'h77);
      6'h1C: step_word = step(1'b0, 4'h0, 3'h7, 4'h0, 8'h5A, 8'hFF);
      6'h1D: step_word = step(1'b1, 4'h0, 3'h7, 4'h0, 8'h5E, 8'hFF);
      6'h20: step_word = step(1'b0, 4'h0, 3'h7, 4'h0, 8'h5E, 8'h77);
      6'h21: step_word = step(1'b0, 4'h0, 3'h7, 4'h0, 8'h5A, 8'h77);
      6'h22: step_word = step(1'b0, 4'h0, 3'h7, 4'h0, 8'h5A, 8'h00);
      6'h30: step_word = step(1'b1, 4'h0, 3'h0, 4'h0, 8'hFF, 8'h00);
      default: step_word = step(1'b0, 4'h0, 3'h0, 4'h0, 8'hFF, 8'h00);
    endcase
  end

endmodule // sequence_step_rom

/* core/write_sequencer.v */
/*
  Control write sequencer: host register port, programmable step store,
  sequence launch, step timing and field writes into the control registers.
  Assumes one 100 MHz clock, a synchronous active-high power-up reset and a
  control register file outside that applies each masked write it is given.
  Assumes the host keeps off the control registers while the busy flag is set;
  such writes are dropped without notice. Reads of the two programming
  registers return the staged words, not the stored step.
*/
// Decided for this implementation: the register addresses and the plain strobed port.
// What this block does
// - Writing 0100h to the launch register runs steps from index 0 onward.
// - Writing 0120h runs the fixed shutdown steps 32 to 48 unattended.
// - Host may rewrite steps 0 to 31 any time; higher steps are fixed.
// - A soft reset through register 0 keeps programmed steps intact.
// - Programmed steps are lost at power-up; defaults come back.
// - After power-up the start-up and shutdown sequences are ready to run.
// - In the default start-up steps only step 29 ends the sequence.
// - Default steps 14, 17, 25, 30, 31 write zero to bit 0 of address FFh.
// - The default start-up sequence lasts about 446.5 ms end to end.
// - Each default step carries its listed fields and runs in index order.
// - Step 13 writes 3 to bits 3:2 of 12h, then waits code 5.
// - Steps 18-21, 26-29 stage 11h, 33h, 77h, FFh into 5Ah and 5Eh.
// - Each step lasts 62.5 us times two to the delay code plus 8.
// - Each step writes only width code plus one low data bits at its start.
// - A step with the end flag stops the sequencer after its delay.
// - Host control writes are refused while the busy flag is set.
`timescale 1ns/100ps
`include "write_sequencer_regs.vh"

module write_sequencer #(
  parameter UNIT_CYCLES = (`STEP_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // Clock and reset.
  input  wire        ref_clk,
  input  wire        rst,
  // Host register port.
  input  wire [7:0]  addr,
  input  wire [15:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [15:0] rdata,
  // Writes into the control registers.
  output reg         ctrl_wr,
  output reg  [7:0]  ctrl_addr,
  output reg  [15:0] ctrl_data,
  output reg  [15:0] ctrl_mask,
  // Status.
  output reg         sequencer_busy_flag
);

  localparam IDLE = 1'b0;
  localparam RUN  = 1'b1;

  // Host-visible sequencer registers.
  reg  [4:0]            write_index;
  reg  [14:0]           target_reg;
  reg  [14:0]           payload_reg;
  reg  [15:0]           launch_reg;

  // Programmable step store and its written-since-power-up flags.
  reg  [`STEP_BITS-1:0] ram [0:`RAM_DEPTH-1];
  reg  [`RAM_DEPTH-1:0] ram_valid;

  // Sequencer state.
  reg                   state;
  reg  [5:0]            cur_index;
  reg  [15:0]           unit_cnt;
  reg  [15:0]           tick_cnt;
  reg                   step_first;

  // Step word and its fields.
  wire [`STEP_BITS-1:0] rom_word;
  wire [`STEP_BITS-1:0] step_word;
  wire [7:0]            step_write_value;
  wire [7:0]            step_addr;
  wire [3:0]            step_field_lsb_position;
  wire [2:0]            step_field_width_code;
  wire [3:0]            step_delay_code;
  wire                  end_of_sequence_flag;
  wire [15:0]           step_ticks;
  wire [15:0]           step_field_mask;

  // Host decode terms.
  wire                  launch_go;
  wire                  soft_reset;
  wire                  host_ctrl_write;
  wire                  launch_hit;

  // Step boundary terms and the field a step writes.
  wire                  unit_last;
  wire                  step_last;
  wire                  seq_last;
  wire [15:0]           step_field_data;

  // Bit mask of a field of width code plus one bits at the given start.
  function [15:0] field_mask;
    input [3:0] start;
    input [2:0] wcode;
    reg   [15:0] m;
    begin
      m = (16'h0001 << ({1'b0, wcode} + 4'h1)) - 16'h0001;
      field_mask = m << start;
    end
  endfunction

  // Builds a step word from the two programming registers.
  function [`STEP_BITS-1:0] pack_step;
    input [14:0] target;
    input [14:0] payload;
    begin
      pack_step = {payload[`PAYLOAD_EOS_BIT],
                   payload[`PAYLOAD_DELAY_LSB+3:`PAYLOAD_DELAY_LSB],
                   target[`TARGET_WIDTH_LSB+2:`TARGET_WIDTH_LSB],
                   target[`TARGET_START_LSB+3:`TARGET_START_LSB],
                   target[7:0],
                   payload[7:0]};
    end
  endfunction

  // True for the two registers whose writes copy a step into the store.
  function store_hit;
    input [7:0] a;
    begin
      store_hit = (a == `OFS_STEP_TARGET) || (a == `OFS_STEP_PAYLOAD);
    end
  endfunction

  sequence_step_rom u_rom (
    .index     (cur_index),
    .step_word (rom_word)
  );

  // A programmed step overrides the default only until the next power-up.
  assign step_word = (cur_index < `RAM_DEPTH && ram_valid[cur_index[4:0]]) ?
                     ram[cur_index[4:0]] : rom_word;

  assign step_write_value        = step_word[`STEP_DATA_LSB+7:`STEP_DATA_LSB];
  assign step_addr               = step_word[`STEP_ADDR_LSB+7:`STEP_ADDR_LSB];
  assign step_field_lsb_position = step_word[`STEP_START_LSB+3:`STEP_START_LSB];
  assign step_field_width_code   = step_word[`STEP_WIDTH_LSB+2:`STEP_WIDTH_LSB];
  assign step_delay_code         = step_word[`STEP_DELAY_LSB+3:`STEP_DELAY_LSB];
  assign end_of_sequence_flag    = step_word[`STEP_EOS_BIT];

  // Step length in units of 62.5 us, execution included.
  assign step_ticks = (16'h0001 << step_delay_code) + `DELAY_OFFSET_TICKS;

  assign step_field_mask = field_mask(step_field_lsb_position, step_field_width_code);

  // Only the low width-code-plus-one data bits reach the field.
  assign step_field_data = ({8'h00, step_write_value} << step_field_lsb_position) & step_field_mask;

  // A step ends after its last unit; a run ends after a flagged step or the final index.
  assign unit_last = (unit_cnt == UNIT_CYCLES[15:0] - 16'h0001);
  assign step_last = unit_last && (tick_cnt == step_ticks - 16'h0001);
  assign seq_last  = step_last && (end_of_sequence_flag || (cur_index == `LAST_INDEX));

  // Launch, soft reset and plain control writes only land while idle.
  assign launch_hit = wr && (addr == `OFS_LAUNCH) && !sequencer_busy_flag;

  assign launch_go = launch_hit && wdata[`LAUNCH_ENABLE_BIT] && (wdata[5:0] <= `LAST_INDEX);

  assign soft_reset = wr && (addr == `OFS_SOFT_RESET) && !sequencer_busy_flag;

  assign host_ctrl_write = wr && !sequencer_busy_flag &&
                           (addr != `OFS_WRITE_INDEX) &&
                           !store_hit(addr) &&
                           (addr != `OFS_LAUNCH) &&
                           (addr != `OFS_STATUS);

  // Sequencer programming registers; a soft reset clears these only.
  always @(posedge ref_clk) begin
    if (rst || soft_reset) begin
      write_index <= `RESET_WRITE_INDEX;
      target_reg  <= `RESET_TARGET;
      payload_reg <= `RESET_PAYLOAD;
      launch_reg  <= `RESET_LAUNCH;
    end else if (wr) begin
      if (addr == `OFS_WRITE_INDEX) begin
        write_index <= wdata[4:0];
      end else if (addr == `OFS_STEP_TARGET) begin
        target_reg <= wdata[14:0];
      end else if (addr == `OFS_STEP_PAYLOAD) begin
        payload_reg <= wdata[14:0];
      end else if (addr == `OFS_LAUNCH && !sequencer_busy_flag) begin
        launch_reg <= wdata;
      end
    end
  end

  // Step store; only indices 0 to 31 exist here, the rest are fixed.
  always @(posedge ref_clk) begin
    if (wr && addr == `OFS_STEP_TARGET) begin
      ram[write_index] <= pack_step(wdata[14:0], payload_reg);
    end else if (wr && addr == `OFS_STEP_PAYLOAD) begin
      ram[write_index] <= pack_step(target_reg, wdata[14:0]);
    end
  end

  // Only power-up clears the flags, so soft resets keep programmed steps.
  always @(posedge ref_clk) begin
    if (rst) begin
      ram_valid <= {`RAM_DEPTH{1'b0}};
    end else if (wr && store_hit(addr)) begin
      ram_valid[write_index] <= 1'b1;
    end
  end

  // Step timing: each step spans step_ticks units of UNIT_CYCLES cycles.
  always @(posedge ref_clk) begin
    if (rst) begin
      state               <= IDLE;
      sequencer_busy_flag <= 1'b0;
      cur_index           <= `STARTUP_INDEX;
      unit_cnt            <= 16'h0000;
      tick_cnt            <= 16'h0000;
      step_first          <= 1'b0;
    end else begin
      case (state)
        IDLE: begin
          step_first <= 1'b0;
          if (launch_go) begin
            state               <= RUN;
            sequencer_busy_flag <= 1'b1;
            cur_index           <= wdata[5:0];
            unit_cnt            <= 16'h0000;
            tick_cnt            <= 16'h0000;
            step_first          <= 1'b1;
          end
        end
        RUN: begin
          step_first <= 1'b0;
          if (unit_last) begin
            unit_cnt <= 16'h0000;
            if (step_last) begin
              tick_cnt <= 16'h0000;
              if (seq_last) begin
                state               <= IDLE;
                sequencer_busy_flag <= 1'b0;
              end else begin
                cur_index  <= cur_index + 6'h01;
                step_first <= 1'b1;
              end
            end else begin
              tick_cnt <= tick_cnt + 16'h0001;
            end
          end else begin
            unit_cnt <= unit_cnt + 16'h0001;
          end
        end
        default: begin
          state               <= IDLE;
          sequencer_busy_flag <= 1'b0;
        end
      endcase
    end
  end

  // Control register writes: the step's masked field, or a host word.
  always @(posedge ref_clk) begin
    if (rst) begin
      ctrl_wr   <= 1'b0;
      ctrl_addr <= 8'h00;
      ctrl_data <= 16'h0000;
      ctrl_mask <= 16'h0000;
    end else if (step_first) begin
      ctrl_wr   <= 1'b1;
      ctrl_addr <= step_addr;
      ctrl_data <= step_field_data;
      ctrl_mask <= step_field_mask;
    end else if (host_ctrl_write) begin
      ctrl_wr   <= 1'b1;
      ctrl_addr <= addr;
      ctrl_data <= wdata;
      ctrl_mask <= 16'hFFFF;
    end else begin
      ctrl_wr <= 1'b0;
    end
  end

  // Read data stand in the cycle after the read strobe only.
  always @(posedge ref_clk) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      if (addr == `OFS_WRITE_INDEX) begin
        rdata <= {11'h000, write_index};
      end else if (addr == `OFS_STEP_TARGET) begin
        rdata <= {1'b0, target_reg};
      end else if (addr == `OFS_STEP_PAYLOAD) begin
        rdata <= {1'b0, payload_reg};
      end else if (addr == `OFS_LAUNCH) begin
        rdata <= launch_reg;
      end else if (addr == `OFS_STATUS) begin
        rdata <= {6'h00, cur_index, 3'h0, sequencer_busy_flag};
      end else begin
        rdata <= 16'h0000;
      end
    end else begin
      rdata <= 16'h0000;
    end
  end

endmodule // write_sequencer

/* dv/write_sequencer_chk.sv */
/*
  Checker of the write sequencer ports: launch, field masks, step spacing and refusals.
  Assumes it is bound to write_sequencer and handed the same UNIT_CYCLES.
*/
`timescale 1ns/100ps

module write_sequencer_chk #(
  parameter UNIT_CYCLES = 6250
) (
  // Clock and reset.
  input wire logic        ref_clk,
  input wire logic        rst,
  // Host register port.
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  // Control writes and status.
  input wire logic        ctrl_wr,
  input wire logic [7:0]  ctrl_addr,
  input wire logic [15:0] ctrl_data,
  input wire logic [15:0] ctrl_mask,
  input wire logic        sequencer_busy_flag
);
  logic [31:0] gap;
  logic        in_run;
  wire         seq_wr = ctrl_wr && ctrl_mask != 16'hFFFF;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Counts cycles since the last sequencer write and notes whether the run has written yet.
  always @(posedge ref_clk) begin
    if (rst) begin
      gap <= 32'h0;
      in_run <= 1'b0;
    end else begin
      gap <= seq_wr ? 32'h1 : gap + 32'h1;
      if (!sequencer_busy_flag)
        in_run <= 1'b0;
      else if (seq_wr)
        in_run <= 1'b1;
    end
  end

  sequence launch_s(w);
    !sequencer_busy_flag && wr && addr == 8'h6F && wdata == w;
  endsequence
  sequence first_step_s;
    sequencer_busy_flag ##1 ctrl_wr;
  endsequence

  start_run_a: assert property (launch_s(16'h0100) |=> first_step_s)
    else $error("Start-up launch gave no busy first step.");
  shutdown_run_a: assert property (launch_s(16'h0120) |=> first_step_s ##0
    (ctrl_addr == 8'h5E && ctrl_mask == 16'h00FF && ctrl_data == 16'h0077))
    else $error("Shutdown launch did not begin at its first fixed step.");
  field_inside_a: assert property (ctrl_wr |-> (ctrl_data & ~ctrl_mask) == 16'h0000)
    else $error("Write data outside its mask.");
  field_width_a: assert property (seq_wr |-> $countones(ctrl_mask) inside {[1:8]} &&
    ((ctrl_mask + (ctrl_mask & -ctrl_mask)) & ctrl_mask) == 16'h0000)
    else $error("Step mask not one field of one to eight bits.");
  busy_refuse_a: assert property (sequencer_busy_flag && wr &&
    !(addr inside {8'h6C, 8'h6D, 8'h6E, 8'h70}) |=> !(ctrl_wr && ctrl_mask == 16'hFFFF))
    else $error("Host write passed while busy.");
  step_time_a: assert property (seq_wr && in_run |->
    gap >= 9 * UNIT_CYCLES && gap % UNIT_CYCLES == 0)
    else $error("Step spacing not a whole step length.");
  last_step_a: assert property ($fell(sequencer_busy_flag) |-> in_run && gap >= 9 * UNIT_CYCLES - 2)
    else $error("Busy fell before the last step finished.");
  idle_quiet_a: assert property (ctrl_wr && !sequencer_busy_flag |-> $past(wr) &&
    ctrl_addr == $past(addr))
    else $error("Control write while idle without a host write.");
endmodule // write_sequencer_chk

/* dv/ctrl_register_file.sv */
/*
  Model of the control register file that receives the sequencer's masked writes.
  Assumes writes arrive as one-cycle pulses on the sequencer's clock.
*/
`timescale 1ns/100ps

module ctrl_register_file (
  // Clock.
  input wire logic        ref_clk,
  // Masked write.
  input wire logic        ctrl_wr,
  input wire logic [7:0]  ctrl_addr,
  input wire logic [15:0] ctrl_data,
  input wire logic [15:0] ctrl_mask
);
  logic [15:0] mem [0:255];

  initial begin
    for (int i = 0; i < 256; i++)
      mem[i] = 16'h0000;
  end

  // Only the bits under the mask change.
  always @(posedge ref_clk) begin
    if (ctrl_wr)
      mem[ctrl_addr] <= (mem[ctrl_addr] & ~ctrl_mask) | (ctrl_data & ctrl_mask);
  end
endmodule // ctrl_register_file

/* dv/test_register_write_sequencer_defaults.sv */
/*
  Testbench of the write sequencer: default and programmed sequences over the host port.
  Assumes a 100 MHz clock and a step unit shortened to four cycles.
*/
`timescale 1ns/100ps

module test_register_write_sequencer_defaults;
  localparam int UC = 4;
  // Host port and outputs.
  logic        ref_clk, rst, wr, rd, ctrl_wr, sequencer_busy_flag;
  logic [7:0]  addr, ctrl_addr;
  logic [15:0] wdata, rdata, ctrl_data, ctrl_mask, rv;
  // Recorded control writes.
  logic [7:0]  p_addr [0:63];
  logic [15:0] p_data [0:63];
  logic [15:0] p_mask [0:63];
  int          p_time [0:63];
  int          n_p, cyc, fail_count, n_tests;

  write_sequencer #(.UNIT_CYCLES(UC)) i_dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .ctrl_wr(ctrl_wr), .ctrl_addr(ctrl_addr), .ctrl_data(ctrl_data),
    .ctrl_mask(ctrl_mask), .sequencer_busy_flag(sequencer_busy_flag));
  ctrl_register_file i_regs (.ref_clk(ref_clk), .ctrl_wr(ctrl_wr), .ctrl_addr(ctrl_addr),
    .ctrl_data(ctrl_data), .ctrl_mask(ctrl_mask));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (ctrl_wr === 1'b1 && n_p < 64) begin
      p_addr[n_p] <= ctrl_addr;
      p_data[n_p] <= ctrl_data;
      p_mask[n_p] <= ctrl_mask;
      p_time[n_p] <= cyc;
      n_p <= n_p + 1;
    end
  end

  task end_sim;
    $display("Checks %0d, errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task rd_reg(input logic [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask

  // The host waits here until the sequencer is idle, for at most 40000 cycles.
  task wait_idle;
    int i;
    #1;
    for (i = 0; i < 40000 && sequencer_busy_flag !== 1'b0; i++) begin
      @(posedge ref_clk);
      #1;
    end
    if (sequencer_busy_flag !== 1'b0) begin
      fail_count++;
      end_sim;
    end
  endtask

  task go(input logic [15:0] d);
    repeat (2) @(posedge ref_clk);
    #1 n_p = 0;
    wr_reg(8'h6F, d);
  endtask

  task step(input int k, input logic [7:0] a, input logic [15:0] m, input logic [15:0] d);
    check("step address", p_addr[k], a);
    check("step mask", p_mask[k], m);
    check("step data", p_data[k], d);
  endtask

  initial begin
    {rst, wr, rd, addr, wdata} = {1'b1, 2'b00, 8'h00, 16'h0000};
    {n_p, cyc, fail_count, n_tests} = 0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    go(16'h0100);
    wait_idle;
    check("start-up writes", n_p, 30);
    step(0, 8'h04, 16'h001F, 16'h001A);
    step(13, 8'h12, 16'h000C, 16'h000C);
    step(14, 8'hFF, 16'h0001, 16'h0000);
    step(18, 8'h5A, 16'h00FF, 16'h0011);
    step(21, 8'h5E, 16'h00FF, 16'h0033);
    step(26, 8'h5A, 16'h00FF, 16'h0077);
    step(29, 8'h5E, 16'h00FF, 16'h00FF);
    check("step 13 time", p_time[14] - p_time[13], UC * 40);
    check("start-up span", p_time[29] - p_time[0], UC * 7135);
    check("dac field", i_regs.mem[8'h12], 16'h000C);
    wr_reg(8'h6C, 16'h001E);
    wr_reg(8'h6D, 16'h3422);
    wr_reg(8'h6E, 16'h405A);
    wr_reg(8'h00, 16'h0000);
    go(16'h011E);
    wait_idle;
    check("programmed writes", n_p, 1);
    step(0, 8'h22, 16'h00F0, 16'h00A0);
    rd_reg(8'h6F);
    check("launch word", rv, 16'h011E);
    go(16'h0120);
    rd_reg(8'h70);
    check("busy running", rv[0], 1);
    wr_reg(8'h33, 16'hBEEF);
    wait_idle;
    rd_reg(8'h70);
    check("busy done", rv[0], 0);
    check("status word", rv, 16'h0300);
    check("refused write", i_regs.mem[8'h33], 16'h0000);
    check("shutdown writes", n_p, 17);
    step(1, 8'h5A, 16'h00FF, 16'h0077);
    go(16'h0121);
    wait_idle;
    check("short shutdown", n_p, 16);
    step(0, 8'h5A, 16'h00FF, 16'h0077);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    go(16'h011E);
    wait_idle;
    check("defaults back", n_p, 19);
    step(0, 8'hFF, 16'h0001, 16'h0000);
    end_sim;
  end
endmodule // test_register_write_sequencer_defaults

bind write_sequencer write_sequencer_chk #(.UNIT_CYCLES(UNIT_CYCLES)) i_chk (.ref_clk(ref_clk), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ctrl_wr(ctrl_wr), .ctrl_addr(ctrl_addr),
  .ctrl_data(ctrl_data), .ctrl_mask(ctrl_mask), .sequencer_busy_flag(sequencer_busy_flag));
